// ===== core/cce_pkg.sv
// shared constants and types for the clear/complement execution block
package cce_pkg;
	// apb register byte offsets
	localparam logic [7:0] CCE_INSTR_OFS  = 8'h00;
	localparam logic [7:0] CCE_WORK_OFS   = 8'h04;
	localparam logic [7:0] CCE_STATUS_OFS = 8'h08;
	localparam logic [7:0] CCE_WDOG_OFS   = 8'h0C;
	localparam logic [7:0] CCE_FADDR_OFS  = 8'h10;
	localparam logic [7:0] CCE_FDATA_OFS  = 8'h14;
	localparam logic [7:0] CCE_COUNT_OFS  = 8'h18;

	// status field positions
	localparam int CCE_ST_ZERO_BIT    = 0;
	localparam int CCE_ST_PWRDN_N_BIT = 1;
	localparam int CCE_ST_TMOUT_N_BIT = 2;
	localparam int CCE_ST_UNKNOWN_BIT = 3;
	localparam int CCE_ST_WIDTH       = 4;
	// watchdog register fields: counter low byte, prescaler next byte
	localparam int CCE_WD_CNT_LSB = 0;
	localparam int CCE_WD_PRE_LSB = 8;

	// reset values
	localparam logic [7:0]              CCE_WORK_RST   = 8'h00;
	localparam logic [CCE_ST_WIDTH-1:0] CCE_STATUS_RST = 4'h6;
	localparam logic [7:0]              CCE_WDOG_RST   = 8'h00;
	localparam logic [13:0]             CCE_INSTR_RST  = 14'h0000;

	// instruction encodings and the masks they are compared under
	localparam logic [13:0] CCE_CLEAR_FILE_PAT  = 14'h0180;
	localparam logic [13:0] CCE_CLEAR_FILE_MSK  = 14'h3F80;
	localparam logic [13:0] CCE_CLEAR_WORK_PAT  = 14'h0103;
	localparam logic [13:0] CCE_INVERT_FILE_PAT = 14'h0900;
	localparam logic [13:0] CCE_INVERT_FILE_MSK = 14'h3F00;
	localparam logic [13:0] CCE_KICK_WDOG_PAT   = 14'h0064;
	localparam logic [13:0] CCE_FULL_MSK        = 14'h3FFF;
	localparam int          CCE_DEST_BIT        = 7;

	// data path sizes and timing
	localparam int CCE_FILE_DEPTH = 128;
	localparam int CCE_ADDR_W     = 7;
	localparam int CCE_EXEC_CYCLES = 1;

	typedef enum logic [2:0]
	{
		CCE_OP_NONE,
		CCE_OP_CLEAR_FILE,
		CCE_OP_CLEAR_WORK,
		CCE_OP_INVERT_FILE,
		CCE_OP_KICK_WDOG
	} cce_op_e;
endpackage : cce_pkg

// ===== core/cce_dec_if.sv
// decoded instruction bundle between decoder and execution core
`timescale 1ns/1ps
interface cce_dec_if;
	import cce_pkg::*;
	logic [13:0]           word;
	cce_op_e               op;
	logic                  to_file;
	logic [CCE_ADDR_W-1:0] faddr;

	modport dec (input word, output op, output to_file, output faddr);
	modport exe (output word, input op, input to_file, input faddr);
endinterface : cce_dec_if

// ===== core/cce_decode.sv
// combinational decoder for the clear and complement instruction group
`timescale 1ns/1ps
module cce_decode
	import cce_pkg::*;
(
	cce_dec_if.dec d
);
	// a word matches a pattern when its masked bits agree
	function automatic logic cce_match(input logic [13:0] w, input logic [13:0] pat,
		input logic [13:0] msk);
		cce_match = ((w & msk) == pat);
	endfunction : cce_match

	wire hit_clear_work  = cce_match(d.word, CCE_CLEAR_WORK_PAT, CCE_FULL_MSK);
	wire hit_kick_wdog   = cce_match(d.word, CCE_KICK_WDOG_PAT, CCE_FULL_MSK);
	wire hit_clear_file  = cce_match(d.word, CCE_CLEAR_FILE_PAT, CCE_CLEAR_FILE_MSK);
	wire hit_invert_file = cce_match(d.word, CCE_INVERT_FILE_PAT, CCE_INVERT_FILE_MSK);

	// fixed patterns first; the clear-work word never overlaps clear-file anyway
	assign d.op = hit_clear_work  ? CCE_OP_CLEAR_WORK :
	              hit_kick_wdog   ? CCE_OP_KICK_WDOG :
	              hit_clear_file  ? CCE_OP_CLEAR_FILE :
	              hit_invert_file ? CCE_OP_INVERT_FILE : CCE_OP_NONE;
	assign d.to_file = d.word[CCE_DEST_BIT];
	assign d.faddr   = d.word[CCE_ADDR_W-1:0];
endmodule : cce_decode

// ===== core/cce_exec.sv
// apb-reached execution core for clear, clear-work, complement and watchdog kick
//
// Contract
// - clear-file writes zero to the addressed file register and sets zero flag
// - clear-work zeroes the working register and sets zero flag; exact word only
// - complement inverts the addressed file register and sets zero from result
// - complement destination bit low goes to working register, high back to file
// - watchdog kick zeroes the watchdog counter and its prescaler
// - watchdog kick sets timeout and powerdown flags, leaves zero flag alone
//
// The register addresses and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module cce_exec
	import cce_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	output logic      [7:0]  work_reg,
	output logic             zero_flag,
	output logic             timeout_flag_n,
	output logic             powerdown_flag_n,
	output logic      [7:0]  watchdog_counter,
	output logic      [7:0]  watchdog_prescale,
	output logic             exec_done
);
	import cce_pkg::*;

	// state
	logic [13:0]             instr_r;
	logic                    pend_r;
	logic [7:0]              work_r;
	logic [CCE_ST_WIDTH-1:0] status_r;
	logic [7:0]              wdog_r;
	logic [7:0]              pre_r;
	logic [CCE_ADDR_W-1:0]   faddr_r;
	logic [15:0]             count_r;
	logic [31:0]             prdata_r;
	logic                    pready_r;
	logic                    pslverr_r;
	logic                    done_r;
	logic [7:0]              file_mem [0:CCE_FILE_DEPTH-1];

	function automatic logic cce_is_zero(input logic [7:0] v);
		cce_is_zero = (v == 8'h00);
	endfunction : cce_is_zero

	// decoder sees the latched word
	cce_dec_if dbus ();
	assign dbus.word = instr_r;
	cce_decode u_dec
	(
		.d (dbus)
	);

	// apb decode; the access cycle before pready is used to register read data
	wire        acc_first = psel & penable & ~pready_r;
	wire        acc_done  = psel & penable & pready_r;
	wire [7:0]  ofs       = paddr[7:0];
	wire        hi_zero   = (paddr[31:8] == 24'h000000) & (paddr[1:0] == 2'b00);
	wire        sel_instr  = hi_zero & (ofs == CCE_INSTR_OFS);
	wire        sel_work   = hi_zero & (ofs == CCE_WORK_OFS);
	wire        sel_status = hi_zero & (ofs == CCE_STATUS_OFS);
	wire        sel_wdog   = hi_zero & (ofs == CCE_WDOG_OFS);
	wire        sel_faddr  = hi_zero & (ofs == CCE_FADDR_OFS);
	wire        sel_fdata  = hi_zero & (ofs == CCE_FDATA_OFS);
	wire        sel_count  = hi_zero & (ofs == CCE_COUNT_OFS);
	wire        mapped     = sel_instr | sel_work | sel_status | sel_wdog | sel_faddr |
	                         sel_fdata | sel_count;
	wire        wr_ok      = acc_done & pwrite & mapped;

	// execution datapath for the latched instruction
	wire [7:0]  src_val   = file_mem[dbus.faddr];
	wire [7:0]  inv_val   = ~src_val;
	wire        ex_live   = pend_r;
	wire        ex_cfile  = ex_live & (dbus.op == CCE_OP_CLEAR_FILE);
	wire        ex_cwork  = ex_live & (dbus.op == CCE_OP_CLEAR_WORK);
	wire        ex_inv    = ex_live & (dbus.op == CCE_OP_INVERT_FILE);
	wire        ex_kick   = ex_live & (dbus.op == CCE_OP_KICK_WDOG);
	wire        ex_bad    = ex_live & (dbus.op == CCE_OP_NONE);
	wire        file_we_x = ex_cfile | (ex_inv & dbus.to_file);
	wire [7:0]  file_wd_x = ex_cfile ? 8'h00 : inv_val;
	wire        work_we_x = ex_cwork | (ex_inv & ~dbus.to_file);
	wire [7:0]  work_wd_x = ex_cwork ? 8'h00 : inv_val;

	// read mux, sampled in the first access cycle
	wire [31:0] rd_mux =
		sel_instr  ? {18'h00000, instr_r} :
		sel_work   ? {24'h000000, work_r} :
		sel_status ? {28'h0000000, status_r} :
		sel_wdog   ? {16'h0000, pre_r, wdog_r} :
		sel_faddr  ? {25'h0000000, faddr_r} :
		sel_fdata  ? {24'h000000, file_mem[faddr_r]} :
		sel_count  ? {16'h0000, count_r} : 32'h00000000;

	// apb handshake: one wait state so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h00000000;
		end
		else
		begin
			pready_r  <= acc_first;
			pslverr_r <= acc_first & ~mapped;
			prdata_r  <= (acc_first & ~pwrite) ? rd_mux : 32'h00000000;
		end
	end

	// instruction latch; a write arms exactly one execution cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			instr_r <= CCE_INSTR_RST;
			pend_r  <= 1'b0;
			done_r  <= 1'b0;
			count_r <= 16'h0000;
		end
		else
		begin
			pend_r <= wr_ok & sel_instr;
			done_r <= pend_r;
			if (wr_ok & sel_instr)
				instr_r <= pwdata[13:0];
			if (pend_r & ~ex_bad)
				count_r <= count_r + 16'h0001;
		end
	end

	// working register: software write first, execution overrides
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			work_r <= CCE_WORK_RST;
		else if (work_we_x)
			work_r <= work_wd_x;
		else if (wr_ok & sel_work)
			work_r <= pwdata[7:0];
	end

	// status flags; hardware sets win over a software clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			status_r <= CCE_STATUS_RST;
		else
		begin
			if (wr_ok & sel_status)
				status_r <= pwdata[CCE_ST_WIDTH-1:0];
			if (ex_cfile | ex_cwork)
				status_r[CCE_ST_ZERO_BIT] <= 1'b1;
			if (ex_inv)
				status_r[CCE_ST_ZERO_BIT] <= cce_is_zero(inv_val);
			if (ex_kick)
			begin
				status_r[CCE_ST_TMOUT_N_BIT] <= 1'b1;
				status_r[CCE_ST_PWRDN_N_BIT] <= 1'b1;
			end
			if (ex_bad)
				status_r[CCE_ST_UNKNOWN_BIT] <= 1'b1;
		end
	end

	// watchdog counter and prescaler; counting itself lives elsewhere
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wdog_r <= CCE_WDOG_RST;
			pre_r  <= CCE_WDOG_RST;
		end
		else if (ex_kick)
		begin
			wdog_r <= CCE_WDOG_RST;
			pre_r  <= CCE_WDOG_RST;
		end
		else if (wr_ok & sel_wdog)
		begin
			wdog_r <= pwdata[CCE_WD_CNT_LSB +: 8];
			pre_r  <= pwdata[CCE_WD_PRE_LSB +: 8];
		end
	end

	// file address pointer for software access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			faddr_r <= '0;
		else if (wr_ok & sel_faddr)
			faddr_r <= pwdata[CCE_ADDR_W-1:0];
	end

	// file register array: no reset, contents are undefined until written
	always_ff @(posedge pclk)
	begin
		if (file_we_x)
			file_mem[dbus.faddr] <= file_wd_x;
		else if (wr_ok & sel_fdata)
			file_mem[faddr_r] <= pwdata[7:0];
	end

	// outputs straight from flops
	assign prdata            = prdata_r;
	assign pready            = pready_r;
	assign pslverr           = pslverr_r;
	assign work_reg          = work_r;
	assign zero_flag         = status_r[CCE_ST_ZERO_BIT];
	assign timeout_flag_n    = status_r[CCE_ST_TMOUT_N_BIT];
	assign powerdown_flag_n  = status_r[CCE_ST_PWRDN_N_BIT];
	assign watchdog_counter  = wdog_r;
	assign watchdog_prescale = pre_r;
	assign exec_done         = done_r;
endmodule : cce_exec

// ===== verification/cce_exec_props.sv
// concurrent checks on the ports of the clear/complement execution block
`timescale 1ns/1ps
module cce_exec_props
	import cce_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [7:0]  work_reg,
	input wire logic        zero_flag,
	input wire logic        timeout_flag_n,
	input wire logic        powerdown_flag_n,
	input wire logic [7:0]  watchdog_counter,
	input wire logic [7:0]  watchdog_prescale,
	input wire logic        exec_done
);
	// an instruction write completing on the bus, decoded by kind
	wire        go = psel && penable && pready && pwrite && paddr == 32'h0;
	wire [13:0] w  = pwdata[13:0];
	wire        cf = go && (w & CCE_CLEAR_FILE_MSK) == CCE_CLEAR_FILE_PAT;
	wire        iv = go && (w & CCE_INVERT_FILE_MSK) == CCE_INVERT_FILE_PAT;
	wire        kk = go && w == CCE_KICK_WDOG_PAT;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// effects are visible two edges after the write, while exec_done is up
	property p_clr_file; cf |-> ##2 exec_done && zero_flag; endproperty
	a_clr_file: assert property (p_clr_file) else $error("clear file effect wrong");
	property p_clr_work; go && w == CCE_CLEAR_WORK_PAT |-> ##2 work_reg == 8'h00 && zero_flag;
	endproperty
	a_clr_work: assert property (p_clr_work) else $error("clear work effect wrong");
	property p_inv_w; iv && !w[CCE_DEST_BIT] |-> ##2 zero_flag == (work_reg == 8'h00); endproperty
	a_inv_w: assert property (p_inv_w) else $error("invert zero flag wrong");
	property p_inv_f; iv && w[CCE_DEST_BIT] |-> ##2 work_reg == $past(work_reg, 2); endproperty
	a_inv_f: assert property (p_inv_f) else $error("invert to file touched work");
	property p_kick; kk |-> ##2 {watchdog_counter, watchdog_prescale} == 16'h0000; endproperty
	a_kick: assert property (p_kick) else $error("watchdog not cleared");
	property p_kick_st; kk |-> ##2 timeout_flag_n && powerdown_flag_n
		&& zero_flag == $past(zero_flag, 2); endproperty
	a_kick_st: assert property (p_kick_st) else $error("kick status wrong");
	property p_timing; go |=> !exec_done ##1 exec_done; endproperty
	a_timing: assert property (p_timing) else $error("execution not one cycle");
	property p_pulse; exec_done |=> !exec_done; endproperty
	a_pulse: assert property (p_pulse) else $error("done pulse too long");
endmodule : cce_exec_props

bind cce_exec cce_exec_props u_props (.*);

// ===== verification/testbench.sv
// self-checking bench for the clear/complement execution block
`timescale 1ns/1ps
module testbench;
	import cce_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
	logic        zero_flag, timeout_flag_n, powerdown_flag_n, exec_done;
	logic [31:0] paddr, pwdata, prdata, q, seed;
	logic [7:0]  work_reg, watchdog_counter, watchdog_prescale, v, wv;
	logic [6:0]  f;
	int          n_errors, n_compared;

	cce_exec dut (.*);

	// counts, verdict and end of run
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : summarize

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			n_errors++;
		end
	endtask : chk

	// one apb transfer; idles a cycle first so no signal is set twice per step
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= {24'h000000, a};
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do
		begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20)
		begin
			n_errors++;
			summarize();
		end
		q   = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	// issue one instruction and wait for its done pulse
	task automatic run(input logic [13:0] w);
		int i;
		apb(1'b1, CCE_INSTR_OFS, {18'h0, w});
		i = 0;
		while (exec_done !== 1'b1 && i < 8)
		begin
			@(posedge pclk);
			i++;
		end
		// a done pulse that never comes is a failure, not a quiet end
		if (i >= 8)
		begin
			n_errors++;
			summarize();
		end
		chk("exec latency", CCE_EXEC_CYCLES + 1, i);
		@(posedge pclk);
		chk("exec pulse", 0, exec_done);
	endtask : run

	task automatic rf(input logic [6:0] a);
		apb(1'b1, CCE_FADDR_OFS, {25'h0, a});
		apb(1'b0, CCE_FDATA_OFS, 32'h0);
	endtask : rf

	initial
	begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// random and corner file values through all four instructions
	initial
	begin
		seed = 32'h7DFB0BCE;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		presetn = 1'b0;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		chk("reset flags", 11'h003, {work_reg, zero_flag, timeout_flag_n, powerdown_flag_n});
		for (int k = 0; k < 6; k++)
		begin
			f  = (k == 0) ? 7'h00 : (k == 1) ? 7'h7F : 7'($random(seed));
			v  = (k == 2) ? 8'hFF : 8'($random(seed));
			wv = (k == 3) ? 8'h00 : 8'($random(seed));
			apb(1'b1, CCE_FADDR_OFS, {25'h0, f});
			apb(1'b1, CCE_FDATA_OFS, {24'h0, v});
			run(CCE_INVERT_FILE_PAT | {7'h00, f});
			chk("inv work", {24'h000000, ~v}, work_reg);
			chk("inv zero", ~v == 8'h00, zero_flag);
			rf(f);
			chk("inv src kept", v, q);
			chk("fdata err", 0, err);
			run(CCE_INVERT_FILE_PAT | 14'h0080 | {7'h00, f});
			rf(f);
			chk("inv to file", {24'h000000, ~v}, q);
			chk("inv work kept", {24'h000000, ~v}, work_reg);
			apb(1'b1, CCE_STATUS_OFS, 32'h0);
			run(CCE_CLEAR_FILE_PAT | {7'h00, f});
			rf(f);
			chk("clear file", {v[0], 8'h00}, {zero_flag ^ ~v[0], q[7:0]});
			apb(1'b1, CCE_WORK_OFS, {24'h0, wv});
			apb(1'b1, CCE_INSTR_OFS, 32'h0102);
			repeat (3) @(posedge pclk);
			chk("near miss", wv, work_reg);
			apb(1'b0, CCE_STATUS_OFS, 32'h0);
			chk("near miss flag", 1, q[CCE_ST_UNKNOWN_BIT]);
			chk("status err", 0, err);
			apb(1'b1, CCE_STATUS_OFS, 32'h0);
			run(CCE_CLEAR_WORK_PAT);
			chk("clear work", 9'h001, {work_reg, zero_flag});
			apb(1'b1, CCE_WDOG_OFS, $random(seed) & 32'hFFFF);
			apb(1'b1, CCE_STATUS_OFS, {31'h0, f[0]});
			run(CCE_KICK_WDOG_PAT);
			chk("kick wdog", 0, {watchdog_counter, watchdog_prescale});
			chk("kick flags", {2'b11, f[0]}, {timeout_flag_n, powerdown_flag_n, zero_flag});
			$display("test pass %0d done", k);
		end
		apb(1'b0, 8'h1C, 32'h0);
		chk("unmapped err", 1, err);
		chk("unmapped data", 0, q);
		// five recognised words per pass; the near miss must not count
		apb(1'b0, CCE_COUNT_OFS, 32'h0);
		chk("exec count", 6 * 5, q);
		summarize();
	end
endmodule : testbench
